// file: pgp_pkg.sv
// Package for the pin data register block: offsets, widths, reset values.
// Assumes a 32-bit register port with full byte addresses.
package pgp_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int unsigned NUM_PINS = 96;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned NUM_WORDS = 3;
	localparam int unsigned ADDR_W = 32;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [31:0] OFS_OUT_LOW = 32'hD00A0018;
	localparam logic [31:0] OFS_OUT_MID = 32'hD00A001C;
	localparam logic [31:0] OFS_OUT_HIGH = 32'hD00A0020;
	localparam logic [31:0] OFS_IN_LOW = 32'hD00A0024;
	localparam logic [31:0] OFS_IN_MID = 32'hD00A0028;
	localparam logic [31:0] OFS_IN_HIGH = 32'hD00A002C;
	localparam logic [31:0] OFS_EN_LOW = 32'hD00A0000;
	localparam logic [31:0] OFS_DIR_LOW = 32'hD00A000C;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] RST_OUT = 32'h00000000;
	localparam logic [31:0] RST_IN = 32'h00000000;
	localparam logic [31:0] RST_EN = 32'h00000000;
	localparam logic [31:0] RST_DIR = 32'hFFFFFFFF;
	localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
endpackage

// file: pgp_sync2.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes inputs are asynchronous to i_ref_clk.
`timescale 1ns/1ps
module pgp_sync2 #(
	parameter int unsigned WIDTH = 96
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// ----------------------------------------
	// Two flip-flops
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule

// file: pgp_pin_data.sv
// What this block does
// - Written output word bits are stored and driven on enabled pins set as outputs.
// - Pins set as inputs are not driven by their output data bit.
// - Output words read back last written value; they reset to zero.
// - Input words read the synchronised pin level for input pins; reset zero.
// - Input word bits of output pins read back the stored output value.
// - Pin is general-purpose only while its enable bit is set.
// - Direction bit set means input; direction bits reset to all ones.
//
// Pin data register block of a 96-pin general-purpose port.
// Assumes enable and direction words come from the neighbouring register set,
// and that pin levels arrive asynchronously from the pads.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module pgp_pin_data #(
	parameter int unsigned NUM_PINS = pgp_pkg::NUM_PINS
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [pgp_pkg::ADDR_W-1:0] i_addr,
	input wire logic [pgp_pkg::WORD_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [pgp_pkg::WORD_W-1:0] o_rdata,
	input wire logic [NUM_PINS-1:0] i_pin_enable,
	input wire logic [NUM_PINS-1:0] i_pin_dir_in,
	input wire logic [NUM_PINS-1:0] i_pin_level,
	output logic [NUM_PINS-1:0] o_pin_out,
	output logic [NUM_PINS-1:0] o_pin_oe,
	output logic [NUM_PINS-1:0] o_pin_gp_sel
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [pgp_pkg::WORD_W-1:0] out_word_ff [pgp_pkg::NUM_WORDS];
	logic [pgp_pkg::WORD_W-1:0] rdata_ff;
	logic [pgp_pkg::WORD_W-1:0] nxt_rdata;
	logic [NUM_PINS-1:0] out_flat;
	logic [NUM_PINS-1:0] level_sync;
	logic [NUM_PINS-1:0] in_view;
	logic [NUM_PINS-1:0] pin_out_ff;
	logic [NUM_PINS-1:0] pin_oe_ff;
	logic [NUM_PINS-1:0] gp_sel_ff;
	logic [NUM_PINS-1:0] enable_ff;
	logic [NUM_PINS-1:0] dir_in_ff;

	// ----------------------------------------
	// Pin level synchroniser
	// ----------------------------------------
	pgp_sync2 #(
		.WIDTH(NUM_PINS)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_async(i_pin_level),
		.o_sync(level_sync)
	);

	// ----------------------------------------
	// Configuration capture
	// ----------------------------------------
	// direction reset ones
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			enable_ff <= '0;
			dir_in_ff <= '1;
		end else begin
			enable_ff <= i_pin_enable;
			dir_in_ff <= i_pin_dir_in;
		end
	end

	// ----------------------------------------
	// Output data words
	// ----------------------------------------
	// store written word
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			for (int k = 0; k < pgp_pkg::NUM_WORDS; k++) begin
				out_word_ff[k] <= pgp_pkg::RST_OUT;
			end
		end else if (i_wr) begin
			case (i_addr)
				pgp_pkg::OFS_OUT_LOW: begin
					out_word_ff[0] <= i_wdata;
				end
				pgp_pkg::OFS_OUT_MID: begin
					out_word_ff[1] <= i_wdata;
				end
				pgp_pkg::OFS_OUT_HIGH: begin
					out_word_ff[2] <= i_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		for (int k = 0; k < pgp_pkg::NUM_WORDS; k++) begin
			out_flat[k*pgp_pkg::WORD_W +: pgp_pkg::WORD_W] = out_word_ff[k];
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// enable gates control
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			pin_out_ff <= '0;
			pin_oe_ff <= '0;
			gp_sel_ff <= '0;
		end else begin
			gp_sel_ff <= enable_ff;
			pin_oe_ff <= enable_ff & ~dir_in_ff;
			pin_out_ff <= out_flat & enable_ff & ~dir_in_ff;
		end
	end

	// ----------------------------------------
	// Input view
	// ----------------------------------------
	// sampled level on input pins, stored output bit on output pins
	assign in_view = (dir_in_ff & level_sync) | (~dir_in_ff & out_flat);

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// read back stored
	always_comb begin
		nxt_rdata = pgp_pkg::RD_UNMAPPED;
		case (i_addr)
			pgp_pkg::OFS_OUT_LOW: begin
				nxt_rdata = out_word_ff[0];
			end
			pgp_pkg::OFS_OUT_MID: begin
				nxt_rdata = out_word_ff[1];
			end
			pgp_pkg::OFS_OUT_HIGH: begin
				nxt_rdata = out_word_ff[2];
			end
			pgp_pkg::OFS_IN_LOW: begin
				nxt_rdata = in_view[31:0];
			end
			pgp_pkg::OFS_IN_MID: begin
				nxt_rdata = in_view[63:32];
			end
			pgp_pkg::OFS_IN_HIGH: begin
				nxt_rdata = in_view[95:64];
			end
			default: begin
				nxt_rdata = pgp_pkg::RD_UNMAPPED;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rdata_ff <= pgp_pkg::RST_IN;
		end else if (i_rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= pgp_pkg::RD_UNMAPPED;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_pin_out = pin_out_ff;
	assign o_pin_oe = pin_oe_ff;
	assign o_pin_gp_sel = gp_sel_ff;
endmodule

// file: pgp_pin_data_asserts.sv
// Checker for the pin data register block.
// Bound to pgp_pin_data; sees only its ports.
`timescale 1ns/1ps
module pgp_pin_data_asserts #(
	parameter int unsigned NUM_PINS = 96
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [NUM_PINS-1:0] i_pin_enable,
	input wire logic [NUM_PINS-1:0] i_pin_dir_in,
	input wire logic [NUM_PINS-1:0] i_pin_level,
	input wire logic [NUM_PINS-1:0] o_pin_out,
	input wire logic [NUM_PINS-1:0] o_pin_oe,
	input wire logic [NUM_PINS-1:0] o_pin_gp_sel
);
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);
	localparam logic [31:0] HI = pgp_pkg::OFS_OUT_HIGH;
	logic [1:0] up;
	wire [NUM_PINS-1:0] drv = i_pin_enable & ~i_pin_dir_in;

	// ----------------------------------------
	// Two clean edges since reset
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			up <= 2'h0;
		end else if (!up[1]) begin
			up <= up + 2'h1;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_idle;
		!i_rd |=> o_rdata == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_back;
		i_wr && i_addr == HI ##1 !i_wr ##1 i_rd && i_addr == HI |=> o_rdata == $past(i_wdata, 3);
	endproperty
	a_back: assert property (p_back) else $error("readback wrong");
	property p_oe;
		up[1] |-> o_pin_oe == $past(drv, 2);
	endproperty
	a_oe: assert property (p_oe) else $error("enable wrong");
	property p_gp;
		up[1] |-> o_pin_gp_sel == $past(i_pin_enable, 2);
	endproperty
	a_gp: assert property (p_gp) else $error("select wrong");
	property p_nodrv;
		~|(o_pin_out & ~o_pin_oe);
	endproperty
	a_nodrv: assert property (p_nodrv) else $error("undriven pin high");
	property p_sel;
		~|(o_pin_oe & ~o_pin_gp_sel);
	endproperty
	a_sel: assert property (p_sel) else $error("drive without select");
	property p_out;
		up[1] && $past(i_wr, 2) && $past(i_addr, 2) == pgp_pkg::OFS_OUT_LOW
			|-> o_pin_out[31:0] == ($past(i_wdata, 2) & o_pin_oe[31:0]);
	endproperty
	a_out: assert property (p_out) else $error("pin level wrong");
	property p_unm;
		i_rd && i_addr == 32'hD00A0030 |=> o_rdata == 32'h0;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");

	// ----------------------------------------
	// Scenarios reached
	// ----------------------------------------
	c_wr: cover property (i_wr ##2 i_rd);
	c_oe: cover property (|o_pin_oe);
	c_sel: cover property (|o_pin_gp_sel);
endmodule

bind pgp_pin_data pgp_pin_data_asserts #(
	.NUM_PINS(NUM_PINS)
) i_chk (
	.i_ref_clk(i_ref_clk),
	.i_reset(i_reset),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.i_pin_enable(i_pin_enable),
	.i_pin_dir_in(i_pin_dir_in),
	.i_pin_level(i_pin_level),
	.o_pin_out(o_pin_out),
	.o_pin_oe(o_pin_oe),
	.o_pin_gp_sel(o_pin_gp_sel)
);

// file: pgp_pin_data_tb.sv
// Testbench for the pin data register block.
// Drives register port and pin inputs directly.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t mismatch", $time); end end
module pgp_pin_data_tb;
logic i_ref_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0;
logic [31:0] i_addr = 0, i_wdata = 0, d, o_rdata;
logic [95:0] en = 0, dir = '1, lvl = 0, m = 0, po, oe, gp;
int miscompares = 0, n_compared = 0, seed = 32'h7a8c, cyc = 0;
pgp_pin_data i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_enable(en),
	.i_pin_dir_in(dir), .i_pin_level(lvl), .o_pin_out(po), .o_pin_oe(oe), .o_pin_gp_sel(gp));
initial forever #2.5 i_ref_clk = ~i_ref_clk;
always @(posedge i_ref_clk) begin
	cyc <= cyc + 1;
	if (cyc == 3000) begin
		miscompares++;
		complete_run();
	end
end
task complete_run();
	$display("miscompares=%0d n_compared=%0d", miscompares, n_compared);
	if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
task wr(input logic [31:0] a, v);
	@(posedge i_ref_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= v; end
	@(posedge i_ref_clk) i_wr <= 0;
endtask
task rd(input logic [31:0] a, e);
	@(posedge i_ref_clk) begin i_rd <= 1; i_addr <= a; end
	@(posedge i_ref_clk) i_rd <= 0;
	#1 `CHK(o_rdata, e)
endtask
function logic [31:0] f_in(int k);
	return m[32*k+:32] & ~dir[32*k+:32] | lvl[32*k+:32] & dir[32*k+:32];
endfunction
initial begin
	repeat (10) @(posedge i_ref_clk);
	i_reset <= 0;
	#1 `CHK(oe, 96'h0)
	`CHK(gp, 96'h0)
	`CHK(po, 96'h0)
	for (int k = 0; k < 3; k++) begin
		rd(pgp_pkg::OFS_OUT_LOW + 4 * k, 0);
		rd(pgp_pkg::OFS_IN_LOW + 4 * k, 0);
	end
	wr(pgp_pkg::OFS_IN_LOW, 32'hFFFFFFFF);
	rd(pgp_pkg::OFS_IN_LOW, 0);
	rd(32'hD00A0030, 0);
	for (int i = 0; i < 30; i++) begin
		@(posedge i_ref_clk) begin
			en <= '0;
			dir <= i ? {$random(seed), $random(seed), $random(seed)} : '0;
			lvl <= {$random(seed), $random(seed), $random(seed)};
		end
		for (int k = 0; k < 3; k++) begin
			d = i ? $random(seed) : 32'hFFFFFFFF;
			wr(pgp_pkg::OFS_OUT_LOW + 4 * k, d);
			m[32*k+:32] = d;
			rd(pgp_pkg::OFS_OUT_LOW + 4 * k, d);
		end
		@(posedge i_ref_clk) en <= i ? {$random(seed), $random(seed), $random(seed)} : '1;
		repeat (3) @(posedge i_ref_clk);
		#1 `CHK(oe, en & ~dir)
		`CHK(po, m & en & ~dir)
		`CHK(gp, en)
		for (int k = 0; k < 3; k++) rd(pgp_pkg::OFS_IN_LOW + 4 * k, f_in(k));
	end
	complete_run();
end
endmodule
